// *** jtm_mapper.sv ***
// module: transport mapper with apb registers and two eight-lane links
`timescale 1ns/1ps
module jtm_mapper (
   input  logic                   pclk,
   input  logic                   presetn,
   input  logic                   psel,
   input  logic                   penable,
   input  logic                   pwrite,
   input  logic [7:0]             paddr,
   input  logic [31:0]            pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  jtm_pkg::jtm_smp_t      smp,
   output logic [15:0][31:0]      lane_data,
   output logic [1:0]             link_vld,
   output logic [15:0]            lane_pd,
   output logic [15:0][2:0]       lane_lid,
   output logic [7:0]             did_a,
   output logic [7:0]             did_b,
   output jtm_pkg::jtm_ovr_t      ovr
);
   import jtm_pkg::*;

   // ------------------------------------------------------------------------
   // mode table
   // ------------------------------------------------------------------------
   function automatic jtm_mode_t mk(
      input logic       e64,
      input logic [5:0] dec,
      input logic       dual,
      input logic [3:0] l,
      input logic [2:0] f,
      input logic [2:0] s,
      input logic [8:0] kmin,
      input logic [3:0] kstep
   );
      jtm_mode_t t;
      t.ok    = 1'b1;
      t.enc64 = e64;
      t.dec   = dec;
      t.dual  = dual;
      t.lanes = l;
      t.m     = dual ? 2'h2 : 2'h1;
      t.f     = f;
      t.s     = s;
      t.e     = e64;
      t.kmin  = kmin;
      t.kstep = kstep;
      return t;
   endfunction

   function automatic jtm_mode_t lookup(input logic [6:0] md);
      jtm_mode_t t;
      t = '0;
      case (md)
         7'h38: t = mk(1'b0, 6'h10, 1'b1, 4'h1, 3'h4, 3'h1, 9'h008, 4'h4);
         7'h39: t = mk(1'b0, 6'h10, 1'b1, 4'h2, 3'h2, 3'h1, 9'h010, 4'h8);
         7'h3A: t = mk(1'b0, 6'h10, 1'b1, 4'h4, 3'h2, 3'h2, 9'h010, 4'h8);
         7'h3B: t = mk(1'b1, 6'h10, 1'b1, 4'h1, 3'h4, 3'h1, 9'h000, 4'h0);
         7'h3C: t = mk(1'b1, 6'h10, 1'b1, 4'h2, 3'h2, 3'h1, 9'h000, 4'h0);
         7'h3D: t = mk(1'b0, 6'h10, 1'b0, 4'h1, 3'h2, 3'h1, 9'h010, 4'h8);
         7'h3E: t = mk(1'b0, 6'h10, 1'b0, 4'h2, 3'h2, 3'h2, 9'h010, 4'h8);
         7'h3F: t = mk(1'b0, 6'h10, 1'b0, 4'h4, 3'h2, 3'h4, 9'h010, 4'h8);
         7'h40: t = mk(1'b1, 6'h10, 1'b0, 4'h1, 3'h2, 3'h1, 9'h000, 4'h0);
         7'h41: t = mk(1'b1, 6'h10, 1'b0, 4'h2, 3'h2, 3'h2, 9'h000, 4'h0);
         7'h42: t = mk(1'b0, 6'h20, 1'b1, 4'h1, 3'h4, 3'h1, 9'h008, 4'h4);
         7'h43: t = mk(1'b0, 6'h20, 1'b1, 4'h2, 3'h2, 3'h1, 9'h010, 4'h8);
         7'h44: t = mk(1'b1, 6'h20, 1'b1, 4'h1, 3'h4, 3'h1, 9'h000, 4'h0);
         7'h45: t = mk(1'b0, 6'h20, 1'b0, 4'h1, 3'h2, 3'h1, 9'h010, 4'h8);
         7'h46: t = mk(1'b0, 6'h20, 1'b0, 4'h2, 3'h2, 3'h2, 9'h010, 4'h8);
         7'h47: t = mk(1'b1, 6'h20, 1'b0, 4'h1, 3'h2, 3'h1, 9'h000, 4'h0);
         default: t = '0;
      endcase
      return t;
   endfunction

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   logic [6:0]  mode_q;
   logic [7:0]  km1_q;
   logic [7:0]  did_q;
   logic [15:0] thr_q;
   logic [1:0]  ctrl_q;
   logic [31:0] rdata_q;
   logic        wr_en;
   logic        setup;
   logic        mapped;
   logic [31:0] rmux;
   logic [31:0] stat;

   assign setup  = psel & ~penable;
   assign wr_en  = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = rdata_q;

   always_comb begin
      case (paddr)
         JTM_OFS_MODE: mapped = 1'b1;
         JTM_OFS_KM1:  mapped = 1'b1;
         JTM_OFS_DID:  mapped = 1'b1;
         JTM_OFS_THR:  mapped = 1'b1;
         JTM_OFS_CTRL: mapped = 1'b1;
         JTM_OFS_STAT: mapped = ~pwrite;
         default:      mapped = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~mapped;

   // mode and length are taken at any time; links must be disabled first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= JTM_MODE_RST;
      end else if (wr_en && paddr == JTM_OFS_MODE) begin
         mode_q <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         km1_q <= JTM_KM1_RST;
      end else if (wr_en && paddr == JTM_OFS_KM1) begin
         km1_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         did_q <= JTM_DID_RST;
      end else if (wr_en && paddr == JTM_OFS_DID) begin
         did_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_q <= JTM_THR_RST;
      end else if (wr_en && paddr == JTM_OFS_THR) begin
         thr_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= JTM_CTRL_RST;
      end else if (wr_en && paddr == JTM_OFS_CTRL) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // ------------------------------------------------------------------------
   // mode decode and K check
   // ------------------------------------------------------------------------
   jtm_mode_t   md;
   logic [8:0]  k_eff;
   logic [8:0]  k_prog;
   logic        k_err;
   logic        run;

   assign md     = lookup(mode_q);
   assign k_prog = {1'b0, km1_q} + 9'h001;

   always_comb begin
      if (md.enc64) begin
         // field ignored: link layer has no multiframe here
         k_eff = (md.f == 3'h4) ? (JTM_K_NUM >> 2) : (JTM_K_NUM >> 1);
         k_err = 1'b0;
      end else begin
         k_eff = k_prog;
         k_err = (k_prog < md.kmin) | (k_prog > JTM_K_MAX);
         if (md.kstep == 4'h4) begin
            k_err = k_err | (k_prog[1:0] != 2'h0);
         end else begin
            k_err = k_err | (k_prog[2:0] != 3'h0);
         end
      end
   end

   // an illegal mode or K keeps every lane quiet
   assign run = ctrl_q[JTM_CTRL_EN] & md.ok & ~k_err;

   always_comb begin
      stat        = '0;
      stat[0]     = ~md.ok;
      stat[1]     = k_err;
      stat[2]     = run;
      stat[3]     = md.enc64;
      stat[7:4]   = md.lanes;
      stat[10:8]  = md.f;
      stat[11]    = md.dual;
      stat[14:12] = md.s;
      stat[24:16] = k_eff;
      stat[30:25] = md.dec;
   end

   always_comb begin
      case (paddr)
         JTM_OFS_MODE: rmux = {25'h0, mode_q};
         JTM_OFS_KM1:  rmux = {24'h0, km1_q};
         JTM_OFS_DID:  rmux = {24'h0, did_q};
         JTM_OFS_THR:  rmux = {16'h0, thr_q};
         JTM_OFS_CTRL: rmux = {30'h0, ctrl_q};
         JTM_OFS_STAT: rmux = stat;
         default:      rmux = 32'h0;
      endcase
   end

   // read data caught in setup, so zero-wait access sees it stable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0;
      end else if (setup && !pwrite) begin
         rdata_q <= rmux;
      end
   end

   // ------------------------------------------------------------------------
   // identifiers
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // b starts one above a so the pair relation holds from reset on
         did_a <= JTM_DID_RST;
         did_b <= JTM_DID_RST + 8'h01;
      end else begin
         did_a <= did_q;
         did_b <= did_q + 8'h01;
      end
   end

   // ------------------------------------------------------------------------
   // overrange detection
   // ------------------------------------------------------------------------
   function automatic logic [13:0] mag(input logic [14:0] x);
      return x[14] ? ~x[13:0] : x[13:0];
   endfunction

   logic [13:0] pk_a;
   logic [13:0] pk_b;
   logic        fa0;
   logic        fa1;
   logic        fb0;
   logic        fb1;
   logic        byp;

   assign byp  = ctrl_q[JTM_CTRL_BYP];
   assign pk_a = (mag(smp.ai) > mag(smp.aq)) ? mag(smp.ai) : mag(smp.aq);
   assign pk_b = (mag(smp.bi) > mag(smp.bq)) ? mag(smp.bi) : mag(smp.bq);
   assign fa0  = pk_a[13:6] > thr_q[7:0];
   assign fa1  = pk_a[13:6] > thr_q[15:8];
   assign fb0  = pk_b[13:6] > thr_q[7:0];
   assign fb1  = pk_b[13:6] > thr_q[15:8];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr <= '0;
      end else if (smp.vld) begin
         ovr.a0 <= md.dual & ~byp & fa0;
         ovr.a1 <= md.dual & ~byp & fa1;
         ovr.b0 <= md.dual & ~byp & fb0;
         ovr.b1 <= md.dual & ~byp & fb1;
         ovr.s0 <= ~md.dual & ~byp & fa0;
         ovr.s1 <= ~md.dual & ~byp & fa1;
      end
   end

   // ------------------------------------------------------------------------
   // word forming per link
   // ------------------------------------------------------------------------
   logic [1:0][15:0] wa;
   logic [1:0][15:0] wb;
   logic [1:0]       per_clk;

   always_comb begin
      if (byp) begin
         wa      = {16'h0, smp.ra, 4'h0};
         wb      = {16'h0, smp.rb, 4'h0};
         per_clk = 2'h1;
      end else if (md.dual) begin
         wa      = {{smp.aq, fa1}, {smp.ai, fa0}};
         wb      = {{smp.bq, fb1}, {smp.bi, fb0}};
         per_clk = 2'h2;
      end else begin
         // one converter: I on link A, Q on link B
         wa      = {16'h0, smp.ai, fa0};
         wb      = {16'h0, smp.aq, fa1};
         per_clk = 2'h1;
      end
   end

   logic [2:0] need;

   assign need = (md.f == 3'h4) ? 3'h2 : md.lanes[2:0];

   // ------------------------------------------------------------------------
   // lane collectors, one per link
   // ------------------------------------------------------------------------
   genvar g;
   genvar i;
   generate
      for (g = 0; g < JTM_LINKS; g++) begin : g_link
         logic [3:0][15:0]           buf_q;
         logic [3:0][15:0]           buf_d;
         logic [2:0]                 ptr_q;
         logic [2:0]                 ptr_d;
         logic [JTM_LANES-1:0][31:0] lane_q;
         logic [JTM_LANES-1:0][31:0] lane_d;
         logic                       vld_q;
         logic                       emit;
         logic [1:0][15:0]           w;

         assign w = (g == 0) ? wa : wb;

         always_comb begin
            buf_d = buf_q;
            buf_d[ptr_q[1:0]] = w[0];
            if (per_clk == 2'h2) begin
               buf_d[2'(ptr_q[1:0] + 2'h1)] = w[1];
            end
            ptr_d = 3'(ptr_q + {1'b0, per_clk});
            emit  = smp.vld && (ptr_d >= need);
         end

         // lanes at or above the lane count stay zero
         always_comb begin
            lane_d = '0;
            for (int n = 0; n < JTM_LANES; n++) begin
               if (md.f == 3'h4 && n == 0) begin
                  lane_d[n] = {buf_d[0], buf_d[1]};
               end else if (n < int'(md.lanes) && md.f != 3'h4) begin
                  lane_d[n] = {buf_d[n % 4], 16'h0};
               end
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ptr_q <= 3'h0;
               buf_q <= '0;
            end else if (!run) begin
               ptr_q <= 3'h0;
            end else if (smp.vld) begin
               buf_q <= buf_d;
               ptr_q <= emit ? 3'h0 : ptr_d;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lane_q <= '0;
               vld_q  <= 1'b0;
            end else if (!run) begin
               lane_q <= '0;
               vld_q  <= 1'b0;
            end else begin
               vld_q <= emit;
               if (emit) begin
                  lane_q <= lane_d;
               end
            end
         end

         assign lane_data[g*JTM_LANES +: JTM_LANES] = lane_q;
         assign link_vld[g] = vld_q;

         for (i = 0; i < JTM_LANES; i++) begin : g_lid
            assign lane_lid[g*JTM_LANES+i] = 3'(i);
         end
      end
   endgenerate

   // ------------------------------------------------------------------------
   // lane power down
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane_pd <= 16'hFFFF;
      end else begin
         for (int n = 0; n < JTM_LANES; n++) begin
            lane_pd[n]           <= ~run | (n >= int'(md.lanes));
            lane_pd[n+JTM_LANES] <= ~run | (n >= int'(md.lanes));
         end
      end
   end

endmodule // jtm_mapper

// *** jtm_mapper_assertions.sv ***
// checker: port relations of the transport mapper
`timescale 1ns/1ps
module jtm_mapper_chk (
   input logic              pclk,
   input logic              presetn,
   input logic              psel,
   input logic              penable,
   input logic              pwrite,
   input logic [7:0]        paddr,
   input logic [31:0]       pwdata,
   input logic [31:0]       prdata,
   input logic              pready,
   input logic              pslverr,
   input jtm_pkg::jtm_smp_t smp,
   input logic [15:0][31:0] lane_data,
   input logic [1:0]        link_vld,
   input logic [15:0]       lane_pd,
   input logic [15:0][2:0]  lane_lid,
   input logic [7:0]        did_a,
   input logic [7:0]        did_b,
   input jtm_pkg::jtm_ovr_t ovr
);
   import jtm_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // identity and lane usage
   // ---------------------------------------------------------------
   property p_did_pair;
      did_b == did_a + 8'h01;
   endproperty
   a_did_pair: assert property (p_did_pair)
      else $error("link b id not link a plus one");
   property p_lid;
      lane_lid == {2{24'hFAC688}};
   endproperty
   a_lid: assert property (p_lid)
      else $error("lane id not its index");
   property p_links_alike;
      lane_pd[15:8] == lane_pd[7:0];
   endproperty
   a_links_alike: assert property (p_links_alike)
      else $error("links use different lanes");
   property p_vld_pair;
      link_vld[0] == link_vld[1];
   endproperty
   a_vld_pair: assert property (p_vld_pair)
      else $error("links framed apart");
   // live lanes must form a run from lane zero
   property p_low_lanes;
      ((~lane_pd[7:0]) & ((~lane_pd[7:0]) + 8'h01)) == 8'h00;
   endproperty
   a_low_lanes: assert property (p_low_lanes)
      else $error("live lanes not lowest");
   property p_upper_off;
      lane_pd[7:4] == 4'hF && lane_pd[15:12] == 4'hF;
   endproperty
   a_upper_off: assert property (p_upper_off)
      else $error("upper lane powered");
   property p_pd_quiet;
      lane_pd[3] |-> lane_data[3] == 32'h0000_0000 && lane_data[11] == 32'h0000_0000;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet)
      else $error("dead lane carries data");
   property p_pad_zero;
      !lane_pd[1] |-> lane_data[0][15:0] == 16'h0000 && lane_data[8][15:0] == 16'h0000;
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("lane pad bits not zero");
endmodule // jtm_mapper_chk

bind jtm_mapper jtm_mapper_chk u_jtm_mapper_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .smp(smp), .lane_data(lane_data), .link_vld(link_vld), .lane_pd(lane_pd),
   .lane_lid(lane_lid), .did_a(did_a), .did_b(did_b), .ovr(ovr));

// *** jtm_mapper_tb.sv ***
// testbench: registers, mode table, lane framing, overrange, bypass
`timescale 1ns/1ps
module jtm_mapper_tb;
   import jtm_pkg::*;
   logic                  pclk;
   logic                  presetn;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [7:0]            paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   jtm_smp_t              smp;
   logic [15:0][31:0]     lane_data;
   logic [1:0]            link_vld;
   logic [15:0]           lane_pd;
   logic [15:0][2:0]      lane_lid;
   logic [7:0]            did_a;
   logic [7:0]            did_b;
   jtm_ovr_t              ovr;
   logic [1:0][3:0][15:0] rx_w;
   logic [31:0]           q;
   logic                  err;
   logic [15:0]           kt [7];
   logic [6:0]            m;
   int                    mismatches;
   int                    comparisons;
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   jtm_mapper u_jtm_mapper (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .smp(smp), .lane_data(lane_data), .link_vld(link_vld), .lane_pd(lane_pd),
      .lane_lid(lane_lid), .did_a(did_a), .did_b(did_b), .ovr(ovr));
   jtm_rx_model u_jtm_rx_model (.pclk(pclk), .lane_data(lane_data), .link_vld(link_vld),
      .lane_pd(lane_pd), .rx_w(rx_w));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         mismatches++;
         wrap_up();
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   // n sample sets, the last one large on channel a when big is set
   task automatic frm(input int n, input logic big);
      int k;
      for (k = 0; k < n; k++) begin
         @(posedge pclk);
         smp <= {1'b1, 15'h0100 + 15'(k) + ((big && k == n - 1) ? 15'h1000 : 15'h0000),
                 15'h0200 + 15'(k), 15'h0300 + 15'(k), 15'h0400 + 15'(k), 12'h100 + 12'(k), 12'h200 + 12'(k)};
      end
      @(posedge pclk);
      smp.vld <= 1'b0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (link_vld[0] !== 1'b1 && k < 8);
      if (k >= 8) begin
         mismatches++;
         wrap_up();
      end
      @(negedge pclk);
   endtask
   function automatic logic [31:0] w16(input logic [14:0] v, input logic f);
      return {16'h0000, v, f};
   endfunction
   // t = {64b66b, decimation, dual, lanes, F, S}
   function automatic logic [31:0] stat_exp(input logic [6:0] md);
      logic [17:0] t;
      case (md)
         7'h38: t = {1'b0, 6'h10, 1'b1, 4'h1, 3'h4, 3'h1};
         7'h39: t = {1'b0, 6'h10, 1'b1, 4'h2, 3'h2, 3'h1};
         7'h3A: t = {1'b0, 6'h10, 1'b1, 4'h4, 3'h2, 3'h2};
         7'h3B: t = {1'b1, 6'h10, 1'b1, 4'h1, 3'h4, 3'h1};
         7'h3C: t = {1'b1, 6'h10, 1'b1, 4'h2, 3'h2, 3'h1};
         7'h3D: t = {1'b0, 6'h10, 1'b0, 4'h1, 3'h2, 3'h1};
         7'h3E: t = {1'b0, 6'h10, 1'b0, 4'h2, 3'h2, 3'h2};
         7'h3F: t = {1'b0, 6'h10, 1'b0, 4'h4, 3'h2, 3'h4};
         7'h40: t = {1'b1, 6'h10, 1'b0, 4'h1, 3'h2, 3'h1};
         7'h41: t = {1'b1, 6'h10, 1'b0, 4'h2, 3'h2, 3'h2};
         7'h42: t = {1'b0, 6'h20, 1'b1, 4'h1, 3'h4, 3'h1};
         7'h43: t = {1'b0, 6'h20, 1'b1, 4'h2, 3'h2, 3'h1};
         7'h44: t = {1'b1, 6'h20, 1'b1, 4'h1, 3'h4, 3'h1};
         7'h45: t = {1'b0, 6'h20, 1'b0, 4'h1, 3'h2, 3'h1};
         7'h46: t = {1'b0, 6'h20, 1'b0, 4'h2, 3'h2, 3'h2};
         default: t = {1'b1, 6'h20, 1'b0, 4'h1, 3'h2, 3'h1};
      endcase
      return {1'b0, t[16:11], (t[17] ? 9'h100 / 9'(t[5:3]) : {1'b0, JTM_KM1_RST} + 9'h001), 1'b0, t[2:0], t[10],
              t[5:3], t[9:6],
              t[17], 3'h0};
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      smp = '0;
      mismatches = 0;
      comparisons = 0;
      kt = '{{7'h3A, 8'h0B, 1'b1}, {7'h38, 8'h0B, 1'b0}, {7'h3A, 8'h13, 1'b1}, {7'h42, 8'h13, 1'b0},
             {7'h3B, 8'h0B, 1'b0}, {7'h3A, 8'hFF, 1'b0}, {7'h38, 8'h03, 1'b1}};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc(JTM_OFS_MODE, 32'h0000_003A);
      rdc(JTM_OFS_KM1, 32'h0000_001F);
      rdc(JTM_OFS_THR, 32'h0000_FFFF);
      chk(32'(lane_pd), 32'h0000_FFFF);
      chk(32'(did_b), 32'h0000_0001);
      rdc(8'h20, 32'h0000_0000);
      chk(32'(err), 32'h1);
      apb(1'b1, JTM_OFS_STAT, 32'hFFFF_FFFF);
      chk(32'(err), 32'h1);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         m = 7'h38 + 7'(i);
         apb(1'b1, JTM_OFS_MODE, 32'(m));
         apb(1'b0, JTM_OFS_STAT, 32'h0000_0000);
         chk(q, stat_exp(m));
      end
      apb(1'b1, JTM_OFS_MODE, 32'h0000_007F);
      apb(1'b0, JTM_OFS_STAT, 32'h0000_0000);
      chk(32'(q[0]), 32'h1);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, JTM_OFS_MODE, 32'(kt[i][15:9]));
         apb(1'b1, JTM_OFS_KM1, 32'(kt[i][8:1]));
         apb(1'b0, JTM_OFS_STAT, 32'h0000_0000);
         chk(32'(q[1]), 32'(kt[i][0]));
      end
      rdc(JTM_OFS_KM1, 32'h0000_0003);
      apb(1'b1, JTM_OFS_KM1, 32'h0000_001F);
      $display("test mode table done");
      // dual channel, four lanes: I and Q alternate over the lanes
      apb(1'b1, JTM_OFS_MODE, 32'h0000_003A);
      apb(1'b1, JTM_OFS_DID, 32'h0000_00FF);
      apb(1'b1, JTM_OFS_CTRL, 32'h0000_0001);
      frm(2, 1'b0);
      for (int k = 0; k < 2; k++) begin
         for (int n = 0; n < 4; n++) begin
            chk(32'(rx_w[k][n]), w16(15'h0100 + 15'(k * 512 + (n % 2) * 256 + n / 2), 1'b0));
         end
      end
      chk(32'(lane_pd), 32'h0000_F0F0);
      chk({16'h0000, did_a, did_b}, 32'h0000_FF00);
      apb(1'b1, JTM_OFS_THR, 32'h0000_8010);
      frm(2, 1'b1);
      chk(32'(rx_w[0][2]), w16(15'h1101, 1'b1));
      chk(32'(rx_w[0][3]), w16(15'h0201, 1'b0));
      chk(32'({ovr.a0, ovr.a1, ovr.b0, ovr.b1}), 32'h8);
      $display("test dual done");
      // single channel, four lanes: I on link a, Q on link b
      apb(1'b1, JTM_OFS_CTRL, 32'h0000_0000);
      apb(1'b1, JTM_OFS_MODE, 32'h0000_003F);
      apb(1'b1, JTM_OFS_CTRL, 32'h0000_0001);
      frm(4, 1'b1);
      for (int n = 0; n < 4; n++) begin
         chk(32'(rx_w[0][n]), w16(15'h0100 + 15'(n) + ((n == 3) ? 15'h1000 : 15'h0000), n == 3));
         chk(32'(rx_w[1][n]), w16(15'h0200 + 15'(n), 1'b0));
      end
      chk(32'({ovr.s0, ovr.s1}), 32'h2);
      $display("test single done");
      // bypass, one lane holding two 12-bit samples with zero tails
      apb(1'b1, JTM_OFS_CTRL, 32'h0000_0000);
      apb(1'b1, JTM_OFS_MODE, 32'h0000_0038);
      apb(1'b1, JTM_OFS_CTRL, 32'h0000_0003);
      frm(2, 1'b0);
      chk(lane_data[0], 32'h1000_1010);
      chk(lane_data[8], 32'h2000_2010);
      chk(32'(lane_pd), 32'h0000_FEFE);
      apb(1'b1, JTM_OFS_CTRL, 32'h0000_0000);
      @(posedge pclk);
      @(negedge pclk);
      chk(32'(lane_pd), 32'h0000_FFFF);
      chk(lane_data[0], 32'h0000_0000);
      $display("test bypass done");
      wrap_up();
   end
endmodule // jtm_mapper_tb

// *** jtm_pkg.sv ***
// package: constants, mode table types and carriers for the transport mapper
// ---------------------------------------------------------------------------
// Behaviour
// - mode 58: 8b10b, dec16 dual, 4 lanes
// - mode 59: 64b66b, dec16 dual, 1 lane
// - mode 60: 64b66b, dec16 dual, 2 lanes
// - modes 61-63: 8b10b dec16 single, 1/2/4 lanes
// - modes 64-65: 64b66b dec16 single, 1/2 lanes
// - modes 66-67: 8b10b dec32 dual, 1/2 lanes
// - mode 68: 64b66b, dec32 dual, 1 lane
// - modes 69-71: dec32 single channel variants
// - 64b66b K fixed at 256*E/F
// - multiframe length from field, checked per mode
// - two links of eight lanes, both used
// - lowest lanes used, upper lanes powered down
// - link A DID, link B DID+1, LID=index
// - bypass samples 12-bit offset binary
// - ddc words: 15-bit data plus overrange bit
// - tail bits are zero
// - samples sent MSB first
// - dual mode per-channel overrange flags
// - single mode two overrange flags
// - mode 56: 8b10b, dec16 dual, 1 lane
// ---------------------------------------------------------------------------
package jtm_pkg;
   // ------------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------------
   localparam logic [7:0]  JTM_OFS_MODE = 8'h00;
   localparam logic [7:0]  JTM_OFS_KM1  = 8'h04;
   localparam logic [7:0]  JTM_OFS_DID  = 8'h08;
   localparam logic [7:0]  JTM_OFS_THR  = 8'h0C;
   localparam logic [7:0]  JTM_OFS_CTRL = 8'h10;
   localparam logic [7:0]  JTM_OFS_STAT = 8'h14;
   localparam logic [6:0]  JTM_MODE_RST = 7'h3A;
   localparam logic [7:0]  JTM_KM1_RST  = 8'h1F;
   localparam logic [7:0]  JTM_DID_RST  = 8'h00;
   localparam logic [15:0] JTM_THR_RST  = 16'hFFFF;
   localparam logic [1:0]  JTM_CTRL_RST = 2'h0;
   localparam int          JTM_CTRL_EN  = 0;
   localparam int          JTM_CTRL_BYP = 1;
   // ------------------------------------------------------------------------
   // link geometry and K arithmetic
   // ------------------------------------------------------------------------
   localparam int          JTM_LANES    = 8;
   localparam int          JTM_LINKS    = 2;
   localparam logic [8:0]  JTM_K_NUM    = 9'h100;
   localparam logic [8:0]  JTM_K_MAX    = 9'h100;
   // ------------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic       ok;
      logic       enc64;
      logic [5:0] dec;
      logic       dual;
      logic [3:0] lanes;
      logic [1:0] m;
      logic [2:0] f;
      logic [2:0] s;
      logic       e;
      logic [8:0] kmin;
      logic [3:0] kstep;
   } jtm_mode_t;
   typedef struct packed {
      logic        vld;
      logic [14:0] ai;
      logic [14:0] aq;
      logic [14:0] bi;
      logic [14:0] bq;
      logic [11:0] ra;
      logic [11:0] rb;
   } jtm_smp_t;
   typedef struct packed {
      logic a0;
      logic a1;
      logic b0;
      logic b1;
      logic s0;
      logic s1;
   } jtm_ovr_t;
endpackage

// *** jtm_rx_model.sv ***
// receiver model: puts each link's words back in time order
`timescale 1ns/1ps
module jtm_rx_model (
   input  logic                  pclk,
   input  logic [15:0][31:0]     lane_data,
   input  logic [1:0]            link_vld,
   input  logic [15:0]           lane_pd,
   output logic [1:0][3:0][15:0] rx_w
);
   // ---------------------------------------------------------------
   // frame capture
   // ---------------------------------------------------------------
   always @(posedge pclk) begin
      if (link_vld[0]) begin
         for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 4; n++) begin
               rx_w[k][n] <= lane_data[8*k+n][31:16];
            end
            // a lone lane in an F=4 mode holds two words per frame
            if (lane_pd[8*k+1]) rx_w[k][1] <= lane_data[8*k][15:0];
         end
      end
   end
endmodule // jtm_rx_model
